// ===== rtl/oscc_top.v
// oscillator prescaler, stabilisation, clock select and stop control
//
// Local design decisions: the address map and the AXI4-Lite register port.
`include "oscc_regs.vh"
module oscc_top #(
  parameter AW = `OSCC_ADDR_W
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          soft_reset,
  input  wire          main_osc_tick,
  input  wire          sub_osc_tick,
  input  wire          stop_req,
  input  wire          wake_irq,
  input  wire [AW-1:0] s_axil_awaddr,
  input  wire          s_axil_awvalid,
  output wire          s_axil_awready,
  input  wire [31:0]   s_axil_wdata,
  input  wire [3:0]    s_axil_wstrb,
  input  wire          s_axil_wvalid,
  output wire          s_axil_wready,
  output wire [1:0]    s_axil_bresp,
  output wire          s_axil_bvalid,
  input  wire          s_axil_bready,
  input  wire [AW-1:0] s_axil_araddr,
  input  wire          s_axil_arvalid,
  output wire          s_axil_arready,
  output wire [31:0]   s_axil_rdata,
  output wire [1:0]    s_axil_rresp,
  output wire          s_axil_rvalid,
  input  wire          s_axil_rready,
  output wire          main_osc_run,
  output wire          sys_clk_tick,
  output wire          timebase_tick,
  output wire          low_power,
  output wire          cpu_hold,
  output wire          por_hold
);
  // ------------------------------------------------------------
  // register index decode
  // ------------------------------------------------------------
  localparam [1:0] IDX_CTRL = 2'h0;
  localparam [1:0] IDX_TB   = 2'h1;
  localparam [1:0] IDX_NONE = 2'h3;

  function [1:0] reg_index;
    input [AW-1:0] addr;
    begin
      if (addr == `OSCC_OFF_CTRL)
        reg_index = IDX_CTRL;
      else if (addr == `OSCC_OFF_TBCTL)
        reg_index = IDX_TB;
      else
        reg_index = IDX_NONE;
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  reg  [1:0]  clock_select_q;
  reg         fast_osc_enable_q;
  reg         timebase_clock_source_q;
  reg         main_osc_ready_flag_q;
  reg         sub_osc_ready_flag_q;
  reg         osc_halt_q;
  reg         por_done_q;
  reg  [1:0]  state_q;
  reg         sub_half_q;

  wire        wr_fire;
  wire [AW-1:0] wr_addr;
  wire [31:0] wr_data;
  wire        wr_lane0;
  wire [AW-1:0] rd_addr;
  reg  [31:0] rd_data;
  wire [1:0]  wr_idx;
  wire [1:0]  rd_idx;

  wire [`OSCC_PRE_W-1:0]  pre_val;
  wire [`OSCC_STAB_W-1:0] stab_val;
  wire [`OSCC_TB_W-1:0]   tb_val;
  wire        pre_carry;
  wire        stab_carry;
  wire        tb_carry;
  wire        main_tick_en;
  wire        div2_tick;
  wire        div4_tick;
  wire        div64_tick;
  wire        sub_div2_tick;
  wire        ctrl_wr;
  wire        en_clear;
  wire        stop_take;
  wire        stop_halts;
  wire        wake;
  wire        sel_main;
  reg         sys_tick_raw;

  assign wr_idx = reg_index(wr_addr);
  assign rd_idx = reg_index(rd_addr);
  assign ctrl_wr = wr_fire & wr_lane0 & (wr_idx == IDX_CTRL);
  // enable bit written from one to zero by software
  assign en_clear = ctrl_wr & fast_osc_enable_q & ~wr_data[`OSCC_CTRL_FOSC_EN] & ~soft_reset;
  assign sel_main = (clock_select_q != `OSCC_SEL_SUB);
  assign stop_take = stop_req & (state_q == `OSCC_ST_RUN) & ~soft_reset;
  // stop halts the oscillator unless it is already off by the enable bit
  assign stop_halts = stop_take & fast_osc_enable_q;
  assign wake = (wake_irq | soft_reset) & (state_q == `OSCC_ST_STOP);

  // ------------------------------------------------------------
  // prescaler and stabilisation counter
  // ------------------------------------------------------------
  // main oscillator runs only while enabled and not halted by stop
  assign main_osc_run = fast_osc_enable_q & ~osc_halt_q;
  assign main_tick_en = main_osc_run & main_osc_tick;

  // 7-bit prescaler; taps at 2, 4, 64, carry at 128
  oscc_count #(
    .W      (`OSCC_PRE_W),
    .PRESET (`OSCC_PRE_PRESET)
  ) u_pre (
    .aclk    (aclk),
    .aresetn (aresetn),
    .preset  (en_clear),
    .clear   (1'b0),       // prescaler kept through stop
    .inc     (main_tick_en),
    .value_q (pre_val),
    .carry   (pre_carry)
  );

  assign div2_tick  = main_tick_en & pre_val[0];
  assign div4_tick  = main_tick_en & (&pre_val[1:0]);
  assign div64_tick = main_tick_en & (&pre_val[5:0]);

  // 6-bit stabilisation counter on the divide-by-128 carry
  oscc_count #(
    .W      (`OSCC_STAB_W),
    .PRESET (`OSCC_STAB_PRESET)
  ) u_stab (
    .aclk    (aclk),
    .aresetn (aresetn),
    .preset  (en_clear),
    .clear   (stop_halts),
    .inc     (pre_carry),
    .value_q (stab_val),
    .carry   (stab_carry)
  );

  // ------------------------------------------------------------
  // time base counter for sub-oscillator readiness
  // ------------------------------------------------------------
  // source bit chooses main divide-by-128 or the free-running sub clock
  assign timebase_tick = timebase_clock_source_q ? pre_carry : sub_osc_tick;

  oscc_count #(
    .W      (`OSCC_TB_W),
    .PRESET (`OSCC_TB_PRESET)
  ) u_tb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .preset  (1'b0),
    .clear   (1'b0),
    .inc     (timebase_tick),
    .value_q (tb_val),
    .carry   (tb_carry)
  );

  // ------------------------------------------------------------
  // system clock selection
  // ------------------------------------------------------------
  // sub-oscillator divided by two
  always @(posedge aclk)
  begin
    if (!aresetn)
      sub_half_q <= 1'b0;
    else if (sub_osc_tick)
      sub_half_q <= ~sub_half_q; // never gated
  end
  assign sub_div2_tick = sub_osc_tick & sub_half_q;

  // select decode of the four sources
  always @*
  begin
    case (clock_select_q)
      `OSCC_SEL_DIV2:  sys_tick_raw = div2_tick;
      `OSCC_SEL_DIV4:  sys_tick_raw = div4_tick;
      `OSCC_SEL_DIV64: sys_tick_raw = div64_tick;
      default:         sys_tick_raw = sub_div2_tick;
    endcase
  end
  // modules halt during stop and while waiting for stabilisation
  assign sys_clk_tick = sys_tick_raw & (state_q == `OSCC_ST_RUN) & por_done_q;

  // ------------------------------------------------------------
  // control and flag registers
  // ------------------------------------------------------------
  // soft reset is an ordinary reset; ready flags survive it
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      clock_select_q          <= `OSCC_SEL_RESET;
      fast_osc_enable_q       <= 1'b1;
      timebase_clock_source_q <= 1'b0;
    end
    else if (soft_reset)
    begin
      clock_select_q          <= `OSCC_SEL_RESET;
      fast_osc_enable_q       <= 1'b1;
      timebase_clock_source_q <= 1'b0;
    end
    else if (wr_fire && wr_lane0)
    begin
      // stop changes none of these control registers, so their values hold through an interrupt wake; a reset wake reloads them
      if (wr_idx == IDX_CTRL)
      begin
        clock_select_q    <= wr_data[`OSCC_CTRL_SEL_HI:`OSCC_CTRL_SEL_LO];
        fast_osc_enable_q <= wr_data[`OSCC_CTRL_FOSC_EN];
      end
      if (wr_idx == IDX_TB)
        timebase_clock_source_q <= wr_data[`OSCC_TBCTL_SRC];
    end
  end

  // ready flags: overflow sets, and a set wins over a clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      main_osc_ready_flag_q <= 1'b0;
      sub_osc_ready_flag_q  <= 1'b0;
      por_done_q            <= 1'b0;
    end
    else
    begin
      if (stab_carry)
        main_osc_ready_flag_q <= 1'b1;
      else if (en_clear || stop_halts)
        main_osc_ready_flag_q <= 1'b0;
      if (tb_carry)
        sub_osc_ready_flag_q <= 1'b1;
      if (stab_carry)
        por_done_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // stop sequencer
  // ------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_q    <= `OSCC_ST_RUN;
      osc_halt_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        `OSCC_ST_RUN:
        begin
          if (stop_take)
          begin
            state_q    <= `OSCC_ST_STOP;
            osc_halt_q <= fast_osc_enable_q;
          end
        end
        `OSCC_ST_STOP:
        begin
          if (wake)
          begin
            // reset wake forces the main source, which needs stabilising
            if (sel_main || soft_reset)
            begin
              osc_halt_q <= 1'b0;
              state_q    <= `OSCC_ST_HOLD;
            end
            else
            begin
              osc_halt_q <= 1'b0;          // off anyway if enable clear
              state_q    <= `OSCC_ST_RUN;
            end
          end
        end
        `OSCC_ST_HOLD:
        begin
          if (stab_carry || (main_osc_ready_flag_q && !fast_osc_enable_q))
            state_q <= `OSCC_ST_RUN;
        end
        default:
          state_q <= `OSCC_ST_RUN;
      endcase
    end
  end

  assign low_power = (state_q == `OSCC_ST_STOP);
  assign cpu_hold  = (state_q != `OSCC_ST_RUN) | ~por_done_q;
  assign por_hold  = ~por_done_q;

  // ------------------------------------------------------------
  // bus slave and read mux
  // ------------------------------------------------------------
  always @*
  begin
    rd_data = 32'h00000000;
    case (rd_idx)
      IDX_CTRL:
      begin
        rd_data[`OSCC_CTRL_MAIN_RDY] = main_osc_ready_flag_q;
        rd_data[`OSCC_CTRL_SUB_RDY]  = sub_osc_ready_flag_q;
        rd_data[`OSCC_CTRL_SEL_HI:`OSCC_CTRL_SEL_LO] = clock_select_q;
        rd_data[`OSCC_CTRL_FOSC_EN]  = fast_osc_enable_q;
      end
      IDX_TB:
        rd_data[`OSCC_TBCTL_SRC] = timebase_clock_source_q;
      default:
        rd_data = 32'h00000000;
    endcase
  end

  oscc_axil #(
    .AW (AW)
  ) u_bus (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .awaddr     (s_axil_awaddr),
    .awvalid    (s_axil_awvalid),
    .awready    (s_axil_awready),
    .wdata      (s_axil_wdata),
    .wstrb      (s_axil_wstrb),
    .wvalid     (s_axil_wvalid),
    .wready     (s_axil_wready),
    .bresp      (s_axil_bresp),
    .bvalid     (s_axil_bvalid),
    .bready     (s_axil_bready),
    .araddr     (s_axil_araddr),
    .arvalid    (s_axil_arvalid),
    .arready    (s_axil_arready),
    .rdata      (s_axil_rdata),
    .rresp      (s_axil_rresp),
    .rvalid     (s_axil_rvalid),
    .rready     (s_axil_rready),
    .wr_fire    (wr_fire),
    .wr_addr_q  (wr_addr),
    .wr_data_q  (wr_data),
    .wr_lane0_q (wr_lane0),
    .wr_ok      (wr_idx != IDX_NONE),
    .rd_addr    (rd_addr),
    .rd_data    (rd_data),
    .rd_ok      (rd_idx != IDX_NONE)
  );
endmodule // oscc_top

// ===== rtl/oscc_regs.vh
// constants of the oscillator and clock control block
// Notes on behaviour
// - a 7-bit prescaler divides the main oscillator; taps at 2, 4, 64 and 128
// - 6-bit stabilisation counter on the divide-by-128 tap; overflow means ready
// - power-on or enable clear presets prescaler and counter to 0078 hex
// - selected system clock feeds all modules except the time base
// - select 00 main/2, 01 main/4, 10 main/64, 11 sub/2
// - reset selects main oscillator divided by two
// - sub-oscillator runs from power-up and is never stopped
// - main oscillator stops on stop instruction or enable bit clear
// - stop on main clock halts oscillator, clears 6-bit counter, prescaler kept
// - stop exit on main clock restarts oscillator, holds cpu until overflow
// - interrupt exit from stop keeps every register unchanged
// - stop on sub with enable halts main; wake restarts it, cpu runs on
// - sub selected, enable clear stops main and presets; set restarts, 8072 counts
// - sub selected, enable clear: wake from stop does not restart main oscillator
// - main ready cleared by power-on, enable clear and a stop that halts main, set on overflow only
// - sub ready cleared by power-on, set after 16264 time base clocks
// - any reset sets the main oscillator enable bit
`ifndef OSCC_REGS_VH
`define OSCC_REGS_VH
// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define OSCC_ADDR_W        8
`define OSCC_OFF_CTRL      8'h00
`define OSCC_OFF_TBCTL     8'h04
// control register fields
`define OSCC_CTRL_MAIN_RDY 7
`define OSCC_CTRL_SUB_RDY  6
`define OSCC_CTRL_SEL_HI   3
`define OSCC_CTRL_SEL_LO   2
`define OSCC_CTRL_FOSC_EN  1
`define OSCC_TBCTL_SRC     0
// ------------------------------------------------------------
// reset and preset values
// ------------------------------------------------------------
`define OSCC_SEL_RESET     2'h0
`define OSCC_SEL_DIV2      2'h0
`define OSCC_SEL_DIV4      2'h1
`define OSCC_SEL_DIV64     2'h2
`define OSCC_SEL_SUB       2'h3
`define OSCC_PRE_W         7
`define OSCC_STAB_W        6
`define OSCC_TB_W          14
`define OSCC_PRE_PRESET    7'h78
`define OSCC_STAB_PRESET   6'h00
`define OSCC_TB_PRESET     14'h0078
// ------------------------------------------------------------
// stop sequencer states
// ------------------------------------------------------------
`define OSCC_ST_RUN        2'h0
`define OSCC_ST_STOP       2'h1
`define OSCC_ST_HOLD       2'h2
// axi response codes
`define OSCC_RESP_OKAY     2'h0
`define OSCC_RESP_SLVERR   2'h2
`endif

// ===== rtl/oscc_count.v
// presettable up-counter with carry out
module oscc_count #(
  parameter           W      = 7,
  parameter [W-1:0]   PRESET = {W{1'b0}}
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         preset,
  input  wire         clear,
  input  wire         inc,
  output reg  [W-1:0] value_q,
  output wire         carry
);
  // carry when the counter wraps on this increment
  assign carry = inc & (&value_q) & ~preset & ~clear;

  // power-on reset loads the preset value
  always @(posedge aclk)
  begin
    if (!aresetn)
      value_q <= PRESET;
    else if (preset)
      value_q <= PRESET;
    else if (clear)
      value_q <= {W{1'b0}};
    else if (inc)
      value_q <= value_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // oscc_count

// ===== rtl/oscc_axil.v
// axi4-lite slave front end for the clock control registers
`include "oscc_regs.vh"
module oscc_axil #(
  parameter AW = 8
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire [AW-1:0] awaddr,
  input  wire          awvalid,
  output wire          awready,
  input  wire [31:0]   wdata,
  input  wire [3:0]    wstrb,
  input  wire          wvalid,
  output wire          wready,
  output reg  [1:0]    bresp,
  output reg           bvalid,
  input  wire          bready,
  input  wire [AW-1:0] araddr,
  input  wire          arvalid,
  output wire          arready,
  output reg  [31:0]   rdata,
  output reg  [1:0]    rresp,
  output reg           rvalid,
  input  wire          rready,
  output wire          wr_fire,
  output reg  [AW-1:0] wr_addr_q,
  output reg  [31:0]   wr_data_q,
  output reg           wr_lane0_q,
  input  wire          wr_ok,
  output wire [AW-1:0] rd_addr,
  input  wire [31:0]   rd_data,
  input  wire          rd_ok
);
  reg aw_got_q;
  reg w_got_q;

  // each channel is taken once until the response is accepted
  assign awready = ~aw_got_q & ~bvalid;
  assign wready  = ~w_got_q & ~bvalid;
  assign wr_fire = aw_got_q & w_got_q & ~bvalid;
  assign arready = ~rvalid;
  assign rd_addr = araddr;

  // write address, data and response
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q   <= 1'b0;
      w_got_q    <= 1'b0;
      wr_addr_q  <= {AW{1'b0}};
      wr_data_q  <= 32'h00000000;
      wr_lane0_q <= 1'b0;
      bvalid     <= 1'b0;
      bresp      <= `OSCC_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_got_q  <= 1'b1;
        wr_addr_q <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_got_q    <= 1'b1;
        wr_data_q  <= wdata;
        wr_lane0_q <= wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= wr_ok ? `OSCC_RESP_OKAY : `OSCC_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // read channel answers one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= `OSCC_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_ok ? `OSCC_RESP_OKAY : `OSCC_RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
  end
endmodule // oscc_axil

// ===== tb/oscc_top_chk.sv
// concurrent checks on the clock control block ports
module oscc_top_chk (
  input logic aclk,
  input logic aresetn,
  input logic soft_reset,
  input logic stop_req,
  input logic wake_irq,
  input logic main_osc_run,
  input logic sys_clk_tick,
  input logic low_power,
  input logic cpu_hold,
  input logic por_hold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // stop taken in run enters low power one cycle later
  stop_entry_a: assert property (stop_req && !cpu_hold && !low_power && !soft_reset |=> low_power)
    else $error("stop request not followed by low power");
  stop_stays_a: assert property (low_power && !wake_irq && !soft_reset |=> low_power)
    else $error("low power left without a wake event");
  stop_halt_a: assert property (low_power |-> !main_osc_run)
    else $error("main oscillator running in stop");
  stop_quiet_a: assert property (low_power |-> !sys_clk_tick)
    else $error("system clock ticks in stop");
  hold_quiet_a: assert property (cpu_hold |-> !sys_clk_tick)
    else $error("system clock ticks while cpu held");
  por_hold_a: assert property (por_hold |-> cpu_hold)
    else $error("cpu released before power-on overflow");
  por_once_a: assert property (!por_hold |=> !por_hold)
    else $error("power-on hold returned without power-on");
  wake_exit_a: assert property (low_power && (wake_irq || soft_reset) |=> !low_power)
    else $error("wake event did not leave stop");
  reset_run_a: assert property (soft_reset |=> main_osc_run)
    else $error("reset did not enable the main oscillator");

  // main scenarios reached
  cover property (stop_req ##1 low_power);
  cover property (low_power ##1 !low_power);
  cover property ($fell(por_hold));
  cover property (sys_clk_tick);
endmodule // oscc_top_chk

bind oscc_top oscc_top_chk oscc_top_chk_inst (
  .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset), .stop_req(stop_req),
  .wake_irq(wake_irq), .main_osc_run(main_osc_run), .sys_clk_tick(sys_clk_tick),
  .low_power(low_power), .cpu_hold(cpu_hold), .por_hold(por_hold)
);

// ===== tb/oscc_osc_model.sv
// model of the two oscillators feeding the clock control block
module oscc_osc_model (
  input  logic aclk,
  input  logic aresetn,
  input  logic main_osc_run,
  output logic main_osc_tick,
  output logic sub_osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    main_osc_tick = 1'b0;
    sub_osc_tick = 1'b0;
  end
  // a halted main oscillator gives no edges at all
  always @(posedge aclk)
    main_osc_tick <= aresetn & main_osc_run;
  // sub oscillator never stops, not even in reset
  always @(posedge aclk)
    sub_osc_tick <= ~sub_osc_tick;
endmodule // oscc_osc_model

// ===== tb/oscc_top_tb.sv
// self-checking bench for the clock control block
`include "oscc_regs.vh"
module oscc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, soft_reset, stop_req, wake_irq, clr;
  logic        main_osc_tick, sub_osc_tick, main_osc_run, sys_clk_tick;
  logic        timebase_tick, low_power, cpu_hold, por_hold;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d, k;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rate [4] = '{32'h80, 32'h40, 32'h4, 32'h40};
  int          tm, ts, n_errors, n_tests;

  oscc_top oscc_top_inst (
    .aclk(aclk), .aresetn(aresetn), .soft_reset(soft_reset),
    .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick),
    .stop_req(stop_req), .wake_irq(wake_irq),
    .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
    .s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid),
    .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
    .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
    .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
    .s_axil_rvalid(rvalid), .s_axil_rready(rready), .main_osc_run(main_osc_run),
    .sys_clk_tick(sys_clk_tick), .timebase_tick(timebase_tick),
    .low_power(low_power), .cpu_hold(cpu_hold), .por_hold(por_hold)
  );
  oscc_osc_model oscc_osc_model_inst (
    .aclk(aclk), .aresetn(aresetn), .main_osc_run(main_osc_run),
    .main_osc_tick(main_osc_tick), .sub_osc_tick(sub_osc_tick)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // oscillator edges seen by the block since the last clear
  always @(posedge aclk)
  begin
    tm <= (!aresetn || clr) ? 0 : tm + int'(main_osc_tick && main_osc_run);
    ts <= (!aresetn || clr) ? 0 : ts + int'(sub_osc_tick);
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one axi4-lite write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        awvalid <= 1'b0;
        ad = 1'b1;
      end
      if (!wd && wready === 1'b1)
      begin
        wvalid <= 1'b0;
        wd = 1'b1;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", bresp, e);
  endtask
  // one axi4-lite read
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input logic [1:0] e);
    rd(a);
    chk("rdata", d, x);
    chk("rresp", r, e);
  endtask
  // one-cycle pulse: 0 stop, 1 wake, 2 ordinary reset
  task automatic pulse(input int w);
    @(posedge aclk);
    if (w == 0) stop_req <= 1'b1;
    else if (w == 1) wake_irq <= 1'b1;
    else soft_reset <= 1'b1;
    @(posedge aclk);
    {stop_req, wake_irq, soft_reset} <= 3'b000;
    repeat (2) @(posedge aclk);
  endtask
  task automatic zero_counts;
    @(posedge aclk);
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  // wait for a ready flag (b<0: cpu release) and check the edge count
  task automatic wait_rdy(input int b, input int lo, input int hi, input int src);
    if (b < 0) do @(posedge aclk); while (cpu_hold !== 1'b0);
    else do rd(`OSCC_OFF_CTRL); while (d[b] !== 1'b1);
    chk("ready count", (src ? ts : tm) >= lo && (src ? ts : tm) <= hi, 1);
  endtask
  // count clock ticks (w=1: time base) over a window
  task automatic cnt(input int cyc, input int w, input logic [31:0] x);
    k = 32'h0;
    repeat (cyc)
    begin
      @(posedge aclk);
      k = k + (w ? timebase_tick : sys_clk_tick);
    end
    chk(w ? "timebase ticks" : "system ticks", k, x);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (100000) @(posedge aclk);
    n_errors++;
    results;
  end
  // main sequence
  initial
  begin
    {aresetn, soft_reset, stop_req, wake_irq, awvalid, wvalid, bready} = '0;
    {arvalid, rready, clr, awaddr, araddr, wdata, wstrb} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`OSCC_OFF_CTRL, 32'h02, `OSCC_RESP_OKAY);
    rdc(`OSCC_OFF_TBCTL, 32'h00, `OSCC_RESP_OKAY);
    chk("por_hold", por_hold, 1);
    wait_rdy(7, 8072, 8080, 0);
    chk("por_hold", por_hold, 0);
    wait_rdy(6, 16264, 16272, 1);
    $display("test power-on done");
    for (int s = 0; s < 4; s++)
    begin
      wr(`OSCC_OFF_CTRL, {28'h0, s[1:0], 2'b10}, `OSCC_RESP_OKAY);
      cnt(256, 0, rate[s]);
    end
    rdc(8'h08, 32'h0, `OSCC_RESP_SLVERR);
    wr(8'h08, 32'h0, `OSCC_RESP_SLVERR);
    rdc(`OSCC_OFF_CTRL, 32'hCE, `OSCC_RESP_OKAY);
    wr(`OSCC_OFF_TBCTL, 32'h1, `OSCC_RESP_OKAY);
    cnt(1280, 1, 32'hA);
    wr(`OSCC_OFF_TBCTL, 32'h0, `OSCC_RESP_OKAY);
    cnt(256, 1, 32'h80);
    $display("test clock select done");
    pulse(0);
    chk("low_power", low_power, 1);
    chk("main_osc_run", main_osc_run, 0);
    cnt(64, 0, 32'h0);
    zero_counts;
    pulse(1);
    chk("low_power", low_power, 0);
    chk("cpu_hold", cpu_hold, 0);
    chk("main_osc_run", main_osc_run, 1);
    rdc(`OSCC_OFF_CTRL, 32'h4E, `OSCC_RESP_OKAY);
    wait_rdy(7, 8064, 8200, 0);
    $display("test stop on sub done");
    wr(`OSCC_OFF_CTRL, 32'h4C, `OSCC_RESP_OKAY);
    chk("main_osc_run", main_osc_run, 0);
    rdc(`OSCC_OFF_CTRL, 32'h4C, `OSCC_RESP_OKAY);
    cnt(256, 0, 32'h40);
    pulse(0);
    pulse(1);
    chk("main_osc_run", main_osc_run, 0);
    chk("low_power", low_power, 0);
    zero_counts;
    wr(`OSCC_OFF_CTRL, 32'h4E, `OSCC_RESP_OKAY);
    wait_rdy(7, 8072, 8080, 0);
    $display("test enable clear done");
    wr(`OSCC_OFF_CTRL, 32'hC2, `OSCC_RESP_OKAY);
    pulse(0);
    chk("low_power", low_power, 1);
    zero_counts;
    pulse(1);
    chk("cpu_hold", cpu_hold, 1);
    wait_rdy(-1, 8064, 8200, 0);
    rdc(`OSCC_OFF_CTRL, 32'hC2, `OSCC_RESP_OKAY);
    cnt(256, 0, 32'h80);
    $display("test stop on main done");
    wr(`OSCC_OFF_CTRL, 32'hCA, `OSCC_RESP_OKAY);
    wr(`OSCC_OFF_TBCTL, 32'h1, `OSCC_RESP_OKAY);
    pulse(2);
    rdc(`OSCC_OFF_CTRL, 32'hC2, `OSCC_RESP_OKAY);
    rdc(`OSCC_OFF_TBCTL, 32'h0, `OSCC_RESP_OKAY);
    $display("test ordinary reset done");
    // ordinary reset as the wake event from stop on the main clock
    pulse(0);
    chk("low_power", low_power, 1);
    zero_counts;
    pulse(2);
    chk("low_power", low_power, 0);
    chk("cpu_hold", cpu_hold, 1);
    wait_rdy(-1, 8064, 8200, 0);
    rdc(`OSCC_OFF_CTRL, 32'hC2, `OSCC_RESP_OKAY);
    $display("test reset wake done");
    results;
  end
endmodule // oscc_top_tb
